// [shared/mps_pkg.sv]
package mps_pkg;
   // Data path shape
   localparam int BYTE_W     = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int LANES      = 4;
   localparam int BIT_CNT_W  = 4;
   // Lane positions inside the pin vectors
   localparam int LANE_ZERO  = 0;
   localparam int LANE_ONE   = 1;
   localparam int LANE_TWO   = 2;
   localparam int LANE_THREE = 3;
   // Reset pulse qualification on lane three, least time rounded up
   localparam int CLK_PERIOD_NS = 5;
   localparam int RST_PULSE_NS  = 200;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CNT_W     = 6;

   typedef enum logic [1:0] {MPS_W1, MPS_W2, MPS_W4} mps_width_t;

   typedef struct packed {
      logic             cs_n;
      logic             test_only_pin;
      logic [LANES-1:0] lane_in;
   } mps_pin_in_t;

   typedef struct packed {
      logic [LANES-1:0] lane_out;
      logic [LANES-1:0] lane_oe;
   } mps_pin_out_t;

   typedef struct packed {
      logic quad_enable_bit;
      logic status_write_lock_nv;
      logic pin_rst_enable_bit;
   } mps_cfg_t;

   typedef struct packed {
      mps_width_t width;
      logic       out_phase;
   } mps_xfer_t;

   typedef struct packed {
      logic valid;
      logic any_reg;
      logic prot_target;
   } mps_wr_cmd_t;
endpackage

// [rtl/mps_sync2.sv]
module mps_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // Two stages; only the second stage is visible
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule

// [rtl/mps_fifo.sv]
module mps_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   input  wire logic         clk_sys,
   input  wire logic         srst,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem_ff [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr;
   logic [AW-1:0] rd_ff, nxt_rd;
   logic [AW:0]   cnt_ff, nxt_cnt;
   logic          push;
   logic          pop;

   // Pointer and fill level update
   always_comb begin
      push    = in_valid && in_ready;
      pop     = out_valid && out_ready;
      nxt_wr  = push ? AW'(wr_ff + 1'b1) : wr_ff;
      nxt_rd  = pop ? AW'(rd_ff + 1'b1) : rd_ff;
      nxt_cnt = (AW+1)'(cnt_ff + (AW+1)'(push) - (AW+1)'(pop));
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // Storage array
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rd_ff];
endmodule

// [rtl/mps_pin_mux.sv]
// Notes on behaviour
// - All traffic crosses a narrow serial pin set of four to six signals.
// - Transfers move one, two or four bits per clock by command width; a four-bit command moves two bits with quad off.
// - Lane zero is serial input in single width, lane zero otherwise.
// - Lane one is serial output in single width, lane one otherwise.
// - Quad off and lock set: lane two is the active-low write guard.
// - Quad on: lane two drops protection and becomes data lane two.
// - Quad on with select low: lane three is only data lane three.
// - Reset enabled: lane three is reset when quad off or select high.
// - Test functions stay inactive while the test pin is low.
// - Inputs captured on rising clock; outputs change after falling edge.
// - Select high: data shifting stops, every output driver released.
// - Reset needs select high and lane three low for the pulse time.
// - Guard low with lock set silently drops protected register writes.
module mps_pin_mux (
   input  wire logic                        clk_sys,
   input  wire logic                        srst,
   input  wire logic                        sck_link,
   input  wire mps_pkg::mps_pin_in_t        pin_i,
   output mps_pkg::mps_pin_out_t            pin_o,
   input  wire mps_pkg::mps_cfg_t           cfg,
   input  wire mps_pkg::mps_xfer_t          xfer,
   input  wire logic [mps_pkg::BYTE_W-1:0]  tx_data,
   input  wire logic                        tx_valid,
   output logic                             tx_ready,
   output logic [mps_pkg::BYTE_W-1:0]       rx_data,
   output logic                             rx_valid,
   input  wire logic                        rx_ready,
   output logic                             rx_overrun,
   input  wire mps_pkg::mps_wr_cmd_t        wr_cmd,
   output logic                             wr_take,
   output logic                             wr_drop,
   output logic                             lane2_is_guard,
   output logic                             lane3_is_reset,
   output logic                             hw_reset,
   output logic                             test_func_active
);
   import mps_pkg::*;

   // Width actually used: four lanes need quad mode
   function automatic mps_width_t eff_width(input mps_width_t w, input logic quad);
      eff_width = (w == MPS_W4 && !quad) ? MPS_W2 : w;
   endfunction

   function automatic logic [BIT_CNT_W-1:0] bits_per_edge(input mps_width_t w);
      unique case (w)
         MPS_W1:  bits_per_edge = 4'h1;
         MPS_W2:  bits_per_edge = 4'h2;
         MPS_W4:  bits_per_edge = 4'h4;
         default: bits_per_edge = 4'h1;
      endcase
   endfunction

   // Registered copy of reset, also clears the link handoff toggles
   logic rst_ff;
   always_ff @(posedge clk_sys) begin
      rst_ff <= srst;
   end

   // Link side settings and transmit request crossing
   logic [4:0]        l_sync;
   logic              tx_req_ff;
   mps_width_t        l_width;
   logic              l_out;
   logic              l_quad;
   logic              l_req;
   logic [3:0]        l_n;
   mps_sync2 #(.W(5)) u_sync_link (
      .clk (sck_link),
      .rst (1'b0),
      .d   ({xfer.width, xfer.out_phase, cfg.quad_enable_bit, tx_req_ff}),
      .q   (l_sync)
   );
   always_comb begin
      l_width = eff_width(mps_width_t'(l_sync[4:3]), l_sync[1]);
      l_out   = l_sync[2];
      l_quad  = l_sync[1];
      l_req   = l_sync[0];
      l_n     = bits_per_edge(l_width);
   end

   // Receive shifter on rising clock, cleared while deselected
   logic [BYTE_W-1:0]    rx_sh_ff, nxt_rx_sh;
   logic [BIT_CNT_W-1:0] rx_cnt_ff, nxt_rx_cnt;
   logic [LANES-1:0]     in_bits;
   logic                 rx_done;
   always_comb begin
      nxt_rx_sh  = rx_sh_ff;
      nxt_rx_cnt = rx_cnt_ff;
      rx_done    = 1'b0;
      unique case (l_width)
         MPS_W1:  in_bits = {3'h0, pin_i.lane_in[LANE_ZERO]};
         MPS_W2:  in_bits = {2'h0, pin_i.lane_in[LANE_ONE:LANE_ZERO]};
         MPS_W4:  in_bits = pin_i.lane_in;
         default: in_bits = '0;
      endcase
      if (!l_out) begin
         nxt_rx_sh  = (rx_sh_ff << l_n) | {4'h0, in_bits};
         nxt_rx_cnt = BIT_CNT_W'(rx_cnt_ff + l_n);
         if (nxt_rx_cnt == BIT_CNT_W'(BYTE_W)) begin
            rx_done    = 1'b1;
            nxt_rx_cnt = '0;
         end
      end
   end
   always_ff @(posedge sck_link or posedge pin_i.cs_n) begin
      if (pin_i.cs_n) begin
         rx_sh_ff  <= '0;
         rx_cnt_ff <= '0;
      end else begin
         rx_sh_ff  <= nxt_rx_sh;
         rx_cnt_ff <= nxt_rx_cnt;
      end
   end

   // Finished byte held steady and announced by a toggle
   logic [BYTE_W-1:0] rx_byte_ff, nxt_rx_byte;
   logic              rx_tgl_ff, nxt_rx_tgl;
   always_comb begin
      nxt_rx_byte = rx_done ? nxt_rx_sh : rx_byte_ff;
      nxt_rx_tgl  = rx_tgl_ff ^ rx_done;
   end
   always_ff @(posedge sck_link or posedge rst_ff) begin
      if (rst_ff) begin
         rx_byte_ff <= '0;
         rx_tgl_ff  <= 1'b0;
      end else begin
         rx_byte_ff <= nxt_rx_byte;
         rx_tgl_ff  <= nxt_rx_tgl;
      end
   end

   // Transmit shifter on falling clock; drivers drop at once on select high
   logic [BYTE_W-1:0]    tx_hold_ff;
   logic [BYTE_W-1:0]    tx_sh_ff, nxt_tx_sh;
   logic [BIT_CNT_W-1:0] tx_cnt_ff, nxt_tx_cnt;
   logic [LANES-1:0]     out_ff, nxt_out;
   logic [LANES-1:0]     oe_ff, nxt_oe;
   logic [BYTE_W-1:0]    tx_cur;
   logic                 ack_ff, nxt_ack;
   logic                 tx_take;
   always_comb begin
      // No byte is taken while deselected, so clocks with select high cannot lose it
      tx_take    = !pin_i.cs_n && (tx_cnt_ff == '0) && l_out && (l_req != ack_ff);
      nxt_ack    = ack_ff ^ tx_take;
      tx_cur     = (tx_cnt_ff == '0) ? (tx_take ? tx_hold_ff : '1) : tx_sh_ff;
      nxt_tx_sh  = tx_sh_ff;
      nxt_tx_cnt = tx_cnt_ff;
      nxt_out    = out_ff;
      nxt_oe     = '0;
      if (l_out) begin
         unique case (l_width)
            MPS_W1: begin
               nxt_out = {2'h0, tx_cur[BYTE_W-1], 1'b0};
               nxt_oe  = 4'h2;
            end
            MPS_W2: begin
               nxt_out = {2'h0, tx_cur[BYTE_W-1 -: 2]};
               nxt_oe  = 4'h3;
            end
            MPS_W4: begin
               nxt_out = tx_cur[BYTE_W-1 -: 4];
               nxt_oe  = 4'hF;
            end
            default: begin
               nxt_out = '0;
               nxt_oe  = '0;
            end
         endcase
         nxt_tx_sh  = tx_cur << l_n;
         nxt_tx_cnt = BIT_CNT_W'(tx_cnt_ff + l_n);
         if (nxt_tx_cnt == BIT_CNT_W'(BYTE_W)) begin
            nxt_tx_cnt = '0;
         end
      end
   end
   always_ff @(negedge sck_link or posedge pin_i.cs_n) begin
      if (pin_i.cs_n) begin
         tx_sh_ff  <= '0;
         tx_cnt_ff <= '0;
         out_ff    <= '0;
         oe_ff     <= '0;
      end else begin
         tx_sh_ff  <= nxt_tx_sh;
         tx_cnt_ff <= nxt_tx_cnt;
         out_ff    <= nxt_out;
         oe_ff     <= nxt_oe;
      end
   end
   always_ff @(negedge sck_link or posedge rst_ff) begin
      if (rst_ff) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= nxt_ack;
      end
   end

   // Pin levels and link toggles into the system clock
   logic [5:0] s_sync;
   logic       s_cs_n, s_test, s_lane3, s_lane2, s_rx_tgl, s_ack;
   mps_sync2 #(.W(6)) u_sync_sys (
      .clk (clk_sys),
      .rst (srst),
      .d   ({pin_i.cs_n, pin_i.test_only_pin, pin_i.lane_in[LANE_THREE:LANE_TWO], rx_tgl_ff, ack_ff}),
      .q   (s_sync)
   );
   assign {s_cs_n, s_test, s_lane3, s_lane2, s_rx_tgl, s_ack} = s_sync;

   // Receive FIFO between the pending byte and the output stage
   logic [BYTE_W-1:0] f_data;
   logic              f_valid, f_ready, f_out_ready;
   logic              pend_ff, nxt_pend;
   logic [BYTE_W-1:0] pend_data_ff, nxt_pend_data;
   mps_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .in_data   (pend_data_ff),
      .in_valid  (pend_ff),
      .in_ready  (f_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_out_ready)
   );

   // System side state
   logic                 rx_seen_ff, nxt_rx_seen;
   logic                 ovr_ff, nxt_ovr;
   logic [BYTE_W-1:0]    rxd_ff, nxt_rxd;
   logic                 rxv_ff, nxt_rxv;
   logic                 nxt_req;
   logic [BYTE_W-1:0]    nxt_hold;
   logic                 txr_ff, nxt_txr;
   logic                 take_ff, nxt_take, drop_ff, nxt_drop;
   logic                 guard_ff, nxt_guard, rrole_ff, nxt_rrole;
   logic [RST_CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
   logic                 hwr_ff, nxt_hwr, test_ff, nxt_test;
   logic                 guard_low, hits_prot, armed, new_rx, accept;
   always_comb begin
      // Protected register writes
      guard_low = cfg.status_write_lock_nv && !cfg.quad_enable_bit && !s_lane2;
      hits_prot = !wr_cmd.any_reg || wr_cmd.prot_target;
      nxt_take  = wr_cmd.valid && !(guard_low && hits_prot);
      nxt_drop  = wr_cmd.valid && guard_low && hits_prot;
      // Pin roles
      nxt_guard = cfg.status_write_lock_nv && !cfg.quad_enable_bit;
      nxt_rrole = cfg.pin_rst_enable_bit && (!cfg.quad_enable_bit || s_cs_n);
      // Hardware reset qualification
      armed       = cfg.pin_rst_enable_bit && s_cs_n && !s_lane3;
      nxt_rst_cnt = '0;
      if (armed) begin
         nxt_rst_cnt = (rst_cnt_ff == RST_CNT_W'(RST_PULSE_CYC)) ? rst_cnt_ff : RST_CNT_W'(rst_cnt_ff + 1'b1);
      end
      nxt_hwr  = armed && (rst_cnt_ff == RST_CNT_W'(RST_PULSE_CYC - 1));
      nxt_test = s_test;
      // Received bytes: pending slot, FIFO, output register
      new_rx        = (s_rx_tgl != rx_seen_ff);
      nxt_rx_seen   = s_rx_tgl;
      nxt_pend      = (pend_ff && !f_ready) || new_rx;
      nxt_pend_data = new_rx ? rx_byte_ff : pend_data_ff;
      nxt_ovr       = ovr_ff || (new_rx && pend_ff && !f_ready);
      f_out_ready   = !rxv_ff || rx_ready;
      nxt_rxv       = f_valid || (rxv_ff && !rx_ready);
      nxt_rxd       = (f_valid && f_out_ready) ? f_data : rxd_ff;
      // Transmit handshake
      accept   = tx_valid && txr_ff;
      nxt_req  = tx_req_ff ^ accept;
      nxt_hold = accept ? tx_data : tx_hold_ff;
      nxt_txr  = (nxt_req == s_ack);
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         take_ff      <= 1'b0;
         drop_ff      <= 1'b0;
         guard_ff     <= 1'b0;
         rrole_ff     <= 1'b0;
         rst_cnt_ff   <= '0;
         hwr_ff       <= 1'b0;
         test_ff      <= 1'b0;
         rx_seen_ff   <= 1'b0;
         pend_ff      <= 1'b0;
         pend_data_ff <= '0;
         ovr_ff       <= 1'b0;
         rxv_ff       <= 1'b0;
         rxd_ff       <= '0;
         tx_req_ff    <= 1'b0;
         tx_hold_ff   <= '0;
         txr_ff       <= 1'b0;
      end else begin
         take_ff      <= nxt_take;
         drop_ff      <= nxt_drop;
         guard_ff     <= nxt_guard;
         rrole_ff     <= nxt_rrole;
         rst_cnt_ff   <= nxt_rst_cnt;
         hwr_ff       <= nxt_hwr;
         test_ff      <= nxt_test;
         rx_seen_ff   <= nxt_rx_seen;
         pend_ff      <= nxt_pend;
         pend_data_ff <= nxt_pend_data;
         ovr_ff       <= nxt_ovr;
         rxv_ff       <= nxt_rxv;
         rxd_ff       <= nxt_rxd;
         tx_req_ff    <= nxt_req;
         tx_hold_ff   <= nxt_hold;
         txr_ff       <= nxt_txr;
      end
   end

   // Outputs straight from flip-flops
   assign pin_o            = '{lane_out: out_ff, lane_oe: oe_ff};
   assign tx_ready         = txr_ff;
   assign rx_data          = rxd_ff;
   assign rx_valid         = rxv_ff;
   assign rx_overrun       = ovr_ff;
   assign wr_take          = take_ff;
   assign wr_drop          = drop_ff;
   assign lane2_is_guard   = guard_ff;
   assign lane3_is_reset   = rrole_ff;
   assign hw_reset         = hwr_ff;
   assign test_func_active = test_ff;

   // Checks
   AST_OE_DESELECT: assert property (@(posedge clk_sys) disable iff (srst) s_cs_n |-> pin_o.lane_oe == '0)
      else $error("driver enabled while deselected");
   AST_LANE23_QUAD: assert property (@(posedge sck_link) disable iff (pin_i.cs_n || rst_ff)
      (|pin_o.lane_oe[3:2]) |-> (l_quad && l_out && l_width == MPS_W4))
      else $error("lane two or three driven outside quad output");
   AST_LANE0_SINGLE: assert property (@(posedge sck_link) disable iff (pin_i.cs_n || rst_ff)
      pin_o.lane_oe[0] |-> l_width != MPS_W1)
      else $error("lane zero driven in single width");
   AST_LANE1_SINGLE: assert property (@(posedge sck_link) disable iff (pin_i.cs_n || rst_ff)
      (l_out && l_width == MPS_W1 && $stable(l_out) && $stable(l_width) && !$past(pin_i.cs_n)) |-> pin_o.lane_oe == 4'h2)
      else $error("single width output not on lane one");
   AST_GUARD_ROLE: assert property (@(posedge clk_sys) disable iff (srst)
      ##1 lane2_is_guard == $past(cfg.status_write_lock_nv && !cfg.quad_enable_bit))
      else $error("lane two role wrong");
   AST_RESET_ROLE: assert property (@(posedge clk_sys) disable iff (srst)
      ##1 lane3_is_reset == $past(cfg.pin_rst_enable_bit && (!cfg.quad_enable_bit || s_cs_n)))
      else $error("lane three role wrong");
   AST_WR_DROP: assert property (@(posedge clk_sys) disable iff (srst)
      (wr_cmd.valid && guard_low && hits_prot) |=> (wr_drop && !wr_take))
      else $error("protected write not dropped");
   AST_WR_TAKE: assert property (@(posedge clk_sys) disable iff (srst)
      (wr_cmd.valid && !(guard_low && hits_prot)) |=> (wr_take && !wr_drop))
      else $error("unprotected write not taken");
   AST_HWRST_TIME: assert property (@(posedge clk_sys) disable iff (srst)
      hw_reset |-> ($past(rst_cnt_ff) == RST_CNT_W'(RST_PULSE_CYC - 1) && $past(s_cs_n, 2)))
      else $error("reset pulse too short or select low");
   AST_TEST_LOW: assert property (@(posedge clk_sys) disable iff (srst) !s_test |=> !test_func_active)
      else $error("test function active with pin low");
   COV_HWRST: cover property (@(posedge clk_sys) disable iff (srst) hw_reset);
   COV_DROP: cover property (@(posedge clk_sys) disable iff (srst) wr_drop);
   COV_RX: cover property (@(posedge clk_sys) disable iff (srst) rx_valid && rx_ready);
   COV_QUAD_OUT: cover property (@(posedge sck_link) disable iff (pin_i.cs_n) pin_o.lane_oe[3]);
endmodule

// [dv/mps_host_model.sv]
// Host side of the serial pins: seven signals in all, sck, select, test pin and four lanes
module mps_host_model (
   output logic                       sck_link,
   output mps_pkg::mps_pin_in_t       pin_i,
   input  wire mps_pkg::mps_pin_out_t pin_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import mps_pkg::*;

   logic       cs_v    = 1'b1;
   logic       test_v  = 1'b0;
   logic       guard_v = 1'b1;
   logic       rst_v   = 1'b1;
   logic       q4      = 1'b0;
   logic [3:0] hoe     = 4'h0;
   logic [3:0] hval    = 4'h0;
   logic [1:0] flt     = 2'h2;
   logic [3:0] hv, ho, fl;

   initial sck_link = 1'b0;

   // Lane level: device driver, then host driver, then pull-up or a decayed value
   always_comb begin
      hv = {q4 ? hval[3:2] : {rst_v, guard_v}, hval[1:0]};
      ho = {q4 ? hoe[3:2] : 2'h3, hoe[1:0]};
      fl = {2'h3, flt};
      pin_i.cs_n = cs_v;
      pin_i.test_only_pin = test_v;
      for (int i = 0; i < LANES; i++) begin
         pin_i.lane_in[i] = pin_o.lane_oe[i] ? pin_o.lane_out[i] : ho[i] ? hv[i] : fl[i];
      end
   end

   task automatic pulse();
      #6 sck_link = 1'b1;
      #6 sck_link = 1'b0;
   endtask

   // Clocks with select high are ignored but carry link settings across
   task automatic settle();
      #1.3;
      repeat (3) pulse();
   endtask

   task automatic begin_frame();
      #1.7 cs_v = 1'b0;
      #6;
   endtask

   // Releasing lanes zero and one leaves the opposite of their last level
   task automatic end_frame();
      #6 cs_v = 1'b1;
      flt = ~hval[1:0];
      hoe = 4'h0;
      q4  = 1'b0;
   endtask

   function automatic int lanes_of(input mps_width_t w);
      return (w == MPS_W1) ? 1 : (w == MPS_W2) ? 2 : 4;
   endfunction

   // Host writes one, two or four bits per rising edge, high bits first
   task automatic send_byte(input mps_width_t w, input logic [7:0] v);
      int n;
      n = lanes_of(w);
      q4 = (n == 4);
      flt[1] = ~hval[1];
      hoe = (n == 1) ? 4'h1 : 4'hF;
      repeat (8 / n) begin
         hval = 4'(v[7:4] >> (4 - n));
         v = v << n;
         pulse();
      end
   endtask

   // Host reads: one clock loads the byte, then a group on each rising edge
   task automatic read_byte(input mps_width_t w, output logic [7:0] v, output logic [3:0] oe);
      int n;
      n = lanes_of(w);
      q4 = (n == 4);
      flt = ~hval[1:0];
      hoe = 4'h0;
      v = 8'h00;
      oe = 4'h0;
      pulse();
      repeat (8 / n) begin
         #6 sck_link = 1'b1;
         v = (n == 1) ? {v[6:0], pin_i.lane_in[1]} : (n == 2) ? {v[5:0], pin_i.lane_in[1:0]} : {v[3:0], pin_i.lane_in};
         oe = pin_o.lane_oe;
         #6 sck_link = 1'b0;
      end
   endtask
endmodule

// [dv/multi_width_serial_if_pin_function_select_tb.sv]
module multi_width_serial_if_pin_function_select_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import mps_pkg::*;

   logic         clk_sys, srst, sck_link, tx_valid, tx_ready, rx_valid, rx_ready, rx_overrun;
   logic         wr_take, wr_drop, lane2_is_guard, lane3_is_reset, hw_reset, test_func_active, dr;
   logic [7:0]   tx_data, rx_data, d;
   logic [3:0]   oe;
   mps_pin_in_t  pin_i;
   mps_pin_out_t pin_o;
   mps_cfg_t     cfg;
   mps_xfer_t    xfer;
   mps_wr_cmd_t  wr_cmd;
   int           err_count = 0;
   int           n_checks = 0;
   int           np, at;
   logic [4:0]   wtab [6] = '{5'h10, 5'h14, 5'h18, 5'h12, 5'h13, 5'h00};
   mps_width_t   wl [3] = '{MPS_W1, MPS_W2, MPS_W4};
   logic [7:0]   rxv [3] = '{8'hB4, 8'h2D, 8'hE1};

   mps_pin_mux dut_u (.clk_sys(clk_sys), .srst(srst), .sck_link(sck_link), .pin_i(pin_i), .pin_o(pin_o),
      .cfg(cfg), .xfer(xfer), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun), .wr_cmd(wr_cmd), .wr_take(wr_take),
      .wr_drop(wr_drop), .lane2_is_guard(lane2_is_guard), .lane3_is_reset(lane3_is_reset),
      .hw_reset(hw_reset), .test_func_active(test_func_active));
   mps_host_model host_u (.sck_link(sck_link), .pin_i(pin_i), .pin_o(pin_o));

   // System clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Watchdog, well past the expected run time
   initial begin
      #100000;
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      final_report();
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic done(input string s);
      $display("test %s finished, %0d mismatches so far", s, err_count);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic pop();
      @(posedge clk_sys) rx_ready <= 1'b1;
      @(posedge clk_sys) rx_ready <= 1'b0;
      @(negedge clk_sys);
   endtask

   // Wait a bounded time for a byte, compare it, then take it
   task automatic get_rx(input logic [7:0] e);
      int i;
      i = 0;
      while (rx_valid !== 1'b1 && i < 200) begin
         @(negedge clk_sys);
         i++;
      end
      check(rx_valid, 1, "rx valid");
      check(rx_data, e, "rx byte");
      pop();
   endtask

   task automatic put_tx(input logic [7:0] v);
      int i;
      i = 0;
      @(posedge clk_sys) tx_data <= v;
      tx_valid <= 1'b1;
      @(negedge clk_sys);
      while (tx_ready !== 1'b1 && i < 50) begin
         @(negedge clk_sys);
         i++;
      end
      @(posedge clk_sys) tx_valid <= 1'b0;
   endtask

   // One link frame of one byte, host writing or reading
   task automatic frame(input mps_width_t w, input logic q, input logic rd, input logic [7:0] v,
                        output logic [7:0] got, output logic [3:0] oes);
      got = 8'h00;
      oes = 4'h0;
      @(posedge clk_sys) xfer <= '{w, rd};
      cfg <= '{q, 1'b0, 1'b0};
      cyc(3);
      // Queue the byte first so the settle clocks carry its request across
      if (rd) put_tx(v);
      host_u.settle();
      host_u.begin_frame();
      if (rd) host_u.read_byte(w, got, oes);
      else host_u.send_byte(w, v);
      host_u.end_frame();
   endtask

   // Hold lane three low for 60 cycles, counting reset pulses
   task automatic rst_try(input logic en, input logic cs, output int p, output int t);
      @(posedge clk_sys) cfg <= '{1'b0, 1'b0, en};
      host_u.cs_v <= cs;
      cyc(4);
      @(posedge clk_sys) host_u.rst_v <= 1'b0;
      p = 0;
      t = 0;
      for (int i = 1; i <= 60; i++) begin
         cyc(1);
         if (hw_reset === 1'b1) begin
            p++;
            t = i;
         end
      end
      @(posedge clk_sys) host_u.rst_v <= 1'b1;
      host_u.cs_v <= 1'b1;
   endtask

   // Main sequence
   initial begin
      srst     = 1'b1;
      cfg      = '0;
      xfer     = '{MPS_W1, 1'b0};
      tx_data  = 8'h00;
      tx_valid = 1'b0;
      rx_ready = 1'b0;
      wr_cmd   = '0;
      repeat (16) @(posedge clk_sys);
      #1;
      check({tx_ready, rx_valid, wr_take, wr_drop, hw_reset, rx_overrun}, 0, "outputs in reset");
      @(posedge clk_sys) srst <= 1'b0;
      cyc(4);
      check(tx_ready, 1, "ready after reset");
      done("reset");
      for (int k = 0; k < 16; k++) begin
         @(posedge clk_sys) cfg <= mps_cfg_t'(k[2:0]);
         host_u.cs_v <= k[3];
         cyc(6);
         check(lane2_is_guard, !k[2] && k[1], "guard role");
         check(lane3_is_reset, k[0] && (!k[2] || k[3]), "reset role");
      end
      done("roles");
      foreach (wtab[j]) begin
         @(posedge clk_sys) cfg <= '{wtab[j][3], wtab[j][4], 1'b0};
         host_u.guard_v <= wtab[j][2];
         cyc(5);
         @(posedge clk_sys) wr_cmd <= '{1'b1, wtab[j][1], wtab[j][0]};
         @(posedge clk_sys) wr_cmd <= '0;
         cyc(0);
         dr = wtab[j][4] && !wtab[j][3] && !wtab[j][2] && (!wtab[j][1] || wtab[j][0]);
         check({wr_drop, wr_take}, {dr, !dr}, "write verdict");
      end
      @(posedge clk_sys) host_u.guard_v <= 1'b1;
      done("writes");
      @(posedge clk_sys) host_u.test_v <= 1'b1;
      cyc(4);
      check(test_func_active, 1, "test pin high");
      @(posedge clk_sys) host_u.test_v <= 1'b0;
      cyc(4);
      check(test_func_active, 0, "test pin low");
      done("test pin");
      rst_try(1'b1, 1'b1, np, at);
      check(np, 1, "one reset pulse");
      check(at >= RST_PULSE_CYC && at <= RST_PULSE_CYC + 4, 1, "reset delay");
      rst_try(1'b1, 1'b0, np, at);
      check(np, 0, "no reset while selected");
      rst_try(1'b0, 1'b1, np, at);
      check(np, 0, "no reset when disabled");
      done("hw reset");
      for (int i = 0; i < 3; i++) begin
         frame(wl[i], 1'b1, 1'b0, rxv[i], d, oe);
         get_rx(rxv[i]);
      end
      host_u.begin_frame();
      for (int j = 0; j < 7; j++) host_u.send_byte(MPS_W4, 8'h10 + 8'(j));
      host_u.end_frame();
      cyc(20);
      check(rx_overrun, 1, "overrun flag");
      for (int j = 0; j < 4; j++) get_rx(8'h10 + 8'(j));
      repeat (4) begin
         cyc(4);
         if (rx_valid === 1'b1) pop();
      end
      cyc(4);
      check(rx_valid, 0, "drained");
      done("receive");
      frame(MPS_W1, 1'b0, 1'b1, 8'h6B, d, oe);
      check(d, 8'h6B, "single read");
      check(oe, 4'h2, "single drivers");
      cyc(1);
      check(pin_o.lane_oe, 4'h0, "released");
      frame(MPS_W2, 1'b0, 1'b1, 8'h5A, d, oe);
      check(d, 8'h5A, "dual read");
      check(oe, 4'h3, "dual drivers");
      frame(MPS_W4, 1'b1, 1'b1, 8'hD2, d, oe);
      check(d, 8'hD2, "quad read");
      check(oe, 4'hF, "quad drivers");
      done("transmit");
      final_report();
   end
endmodule
